/* ppfs_pkg.sv */
// shared constants and types for the port pin function selector
package ppfs_pkg;

   // ----------------------------------------------------------------
   // operating modes
   // ----------------------------------------------------------------
   typedef enum logic [3:0]
   {
      PPFS_MODE_4 = 4'b0001,
      PPFS_MODE_5 = 4'b0010,
      PPFS_MODE_6 = 4'b0100,
      PPFS_MODE_7 = 4'b1000
   } ppfs_mode_t;

   localparam logic [2:0] PPFS_MD_CODE_4 = 3'h4;
   localparam logic [2:0] PPFS_MD_CODE_5 = 3'h5;
   localparam logic [2:0] PPFS_MD_CODE_6 = 3'h6;
   localparam logic [2:0] PPFS_MD_CODE_7 = 3'h7;

   // ----------------------------------------------------------------
   // widths, reset values, timing counts
   // ----------------------------------------------------------------
   localparam int PPFS_SYNC_W = 6;
   localparam int PPFS_TOP_ADDR_W = 4;
   localparam logic [1:0] PPFS_LOCK_CYCLES = 2'h2;
   localparam logic [1:0] PPFS_LOCK_RST = 2'h0;
   localparam ppfs_mode_t PPFS_MODE_RST = PPFS_MODE_4;
   localparam logic PPFS_CS0_DIR_RST = 1'b0;
   localparam logic [7:0] PPFS_BYTE_RST = 8'h00;
   localparam logic [4:0] PPFS_PG_RST = 5'h00;
   localparam logic [3:0] PPFS_NIB_RST = 4'h0;
   localparam logic [5:0] PPFS_IRQ_RST = 6'h00;

   // ----------------------------------------------------------------
   // pin positions
   // ----------------------------------------------------------------
   localparam int PPFS_PF_CLK = 7;
   localparam int PPFS_PF_AS = 6;
   localparam int PPFS_PF_RD = 5;
   localparam int PPFS_PF_HWR = 4;
   localparam int PPFS_PF_LWR = 3;
   localparam int PPFS_PF_WAIT = 2;
   localparam int PPFS_PF_BACK = 1;
   localparam int PPFS_PF_BUS_REQUEST_IN = 0;
   localparam int PPFS_PG_CS0 = 4;
   localparam int PPFS_PG_CS1 = 3;
   localparam int PPFS_PG_CS2 = 2;
   localparam int PPFS_PG_CS3 = 1;
   localparam int PPFS_PG_TRG = 0;

endpackage

/* ppfs_sync.sv */
// two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module ppfs_sync
   import ppfs_pkg::*;
#(
   parameter int WIDTH = PPFS_SYNC_W
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // ----------------------------------------------------------------
   // per-bit flop pairs
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++)
      begin : g_bit
         logic meta_q;
         logic meta_d;
         logic stab_q;
         logic stab_d;
         always_comb
         begin
            meta_d = clk_en ? async_in[gi] : meta_q;
            stab_d = clk_en ? meta_q : stab_q;
         end
         always_ff @(posedge sys_clk)
         begin
            // straps must be settled when reset lifts, so the chain
            // keeps filling through reset whatever the enable
            if (!rst_n)
            begin
               meta_q <= async_in[gi];
               stab_q <= meta_q;
            end
            else
            begin
               meta_q <= meta_d;
               stab_q <= stab_d;
            end
         end
         assign sync_out[gi] = stab_q;
      end
   endgenerate

endmodule
`default_nettype wire

/* ppfs_top.sv */
// pin function multiplexer for the bus data, bus control, chip select and top address ports
`timescale 1ns/1ps
`default_nettype none
// Operation
// - the low data byte port is general I/O in 8-bit bus modes and always in single-chip mode.
// - the clock pin is an input while its direction bit is 0 (reset) and drives the clock at 1.
// - in 8-bit bus mode the low write strobe pin becomes I/O when its disable bit is 1.
// - with the wait enable bit at 1 the shared pin is the bus wait input, else an I/O port.
// - chip select 4 is driven only when the 2-5 enable, its pin select and direction are all 1.
// - with bus release enabled the pins take a bus request in and drive a bus acknowledge out.
// - after reset in mode 4 or 5 the chip select 0 direction defaults to output, not in mode 6.
// - the upper address port has pins shared with timer channels and top address outputs by mode.
// - each top address pin picks address or port data by its own address enable bit.
// - variants without internal program memory only offer modes 4 and 5.
// - with address enable and direction at 1 the pin drives the address, else port data.
// - the 3-or-6 choice bit selects chip select 3 or 6 on the shared chip select pin.
module ppfs_top
   import ppfs_pkg::*;
#(
   parameter bit HAS_INT_ROM = 1'b1
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [2:0] mode_pins,
   input wire logic bus_width_8,
   input wire logic addr_strobe_disable,
   input wire logic low_write_strobe_disable,
   input wire logic wait_input_enable,
   input wire logic chip_sel_2_to_5_enable,
   input wire logic chip_sel_4_pin_select,
   input wire logic chip_sel_5_pin_select,
   input wire logic chip_sel_3_or_6_choice,
   input wire logic chip_sel_1_or_7_choice,
   input wire logic chip_sel_1_6_7_enable,
   input wire logic bus_release_enable,
   input wire logic [3:0] top_addr_enable,
   input wire logic cs0_dir_wr,
   input wire logic cs0_dir_wdata,
   input wire logic clk_out_level,
   input wire logic [3:0] addr_top,
   input wire logic address_strobe_n,
   input wire logic read_strobe_n,
   input wire logic high_write_strobe_n,
   input wire logic low_write_strobe_n,
   input wire logic bus_ack_n,
   input wire logic [7:0] chip_sel_n,
   input wire logic [7:0] data_lo_out,
   input wire logic data_lo_drive,
   input wire logic [3:0] timer_out,
   input wire logic [3:0] timer_oe,
   input wire logic [7:0] pe_dr,
   input wire logic [7:0] pe_ddr,
   input wire logic [7:0] pf_dr,
   input wire logic [7:0] pf_ddr,
   input wire logic [4:0] pg_dr,
   input wire logic [3:0] pg_ddr_low,
   input wire logic [3:0] p1_dr,
   input wire logic [3:0] p1_ddr,
   input wire logic [3:0] pf_pin_in,
   input wire logic [1:0] pg_pin_in,
   output ppfs_mode_t op_mode,
   output logic cs0_dir,
   output logic [7:0] pe_out,
   output logic [7:0] pe_oe,
   output logic [7:0] pf_out,
   output logic [7:0] pf_oe,
   output logic [4:0] pg_out,
   output logic [4:0] pg_oe,
   output logic [3:0] p1_out,
   output logic [3:0] p1_oe,
   output logic wait_to_bus,
   output logic bus_request_in,
   output logic converter_trigger_in,
   output logic [5:0] irq_level
);

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   function automatic ppfs_mode_t decode_mode(input logic [2:0] md, input bit rom);
      ppfs_mode_t m;
      m = PPFS_MODE_4;
      unique case (md)
         PPFS_MD_CODE_5: m = PPFS_MODE_5;
         PPFS_MD_CODE_6: m = rom ? PPFS_MODE_6 : PPFS_MODE_4;
         PPFS_MD_CODE_7: m = rom ? PPFS_MODE_7 : PPFS_MODE_4;
         default: m = PPFS_MODE_4;
      endcase
      return m;
   endfunction

   logic [2:0] mode_sync;
   logic [PPFS_SYNC_W-1:0] pin_sync;

   // mode straps are pins, so they cross two flops before anyone looks
   ppfs_sync #(.WIDTH(3)) u_mode_sync
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .async_in(mode_pins),
      .sync_out(mode_sync)
   );

   ppfs_sync #(.WIDTH(PPFS_SYNC_W)) u_pin_sync
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .async_in({pg_pin_in, pf_pin_in}),
      .sync_out(pin_sync)
   );

   // ----------------------------------------------------------------
   // mode capture and chip select 0 direction
   // ----------------------------------------------------------------
   ppfs_mode_t mode_q;
   ppfs_mode_t mode_d;
   logic [1:0] lock_q;
   logic [1:0] lock_d;
   logic cs0_dir_q;
   logic cs0_dir_d;
   ppfs_mode_t new_mode;

   always_comb
   begin
      mode_d = mode_q;
      lock_d = lock_q;
      cs0_dir_d = cs0_dir_q;
      // illegal straps fall back to mode 4
      new_mode = decode_mode(mode_sync, HAS_INT_ROM);
      if (clk_en)
      begin
         // straps sampled until the synchroniser has filled after reset
         if (lock_q != PPFS_LOCK_CYCLES)
         begin
            mode_d = new_mode;
            lock_d = lock_q + 2'h1;
            // direction default decided once the mode is known
            cs0_dir_d = (new_mode == PPFS_MODE_4) || (new_mode == PPFS_MODE_5);
         end
         else if (cs0_dir_wr)
         begin
            cs0_dir_d = cs0_dir_wdata;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         mode_q <= PPFS_MODE_RST;
         lock_q <= PPFS_LOCK_RST;
         cs0_dir_q <= PPFS_CS0_DIR_RST;
      end
      else
      begin
         mode_q <= mode_d;
         lock_q <= lock_d;
         cs0_dir_q <= cs0_dir_d;
      end
   end

   // ----------------------------------------------------------------
   // pin function selection
   // ----------------------------------------------------------------
   logic bus_mode;
   logic [7:0] pe_out_q, pe_out_d, pe_oe_q, pe_oe_d;
   logic [7:0] pf_out_q, pf_out_d, pf_oe_q, pf_oe_d;
   logic [4:0] pg_out_q, pg_out_d, pg_oe_q, pg_oe_d;
   logic [3:0] p1_out_q, p1_out_d, p1_oe_q, p1_oe_d;
   logic wait_q, wait_d, bus_request_in_q, bus_request_in_d, trg_q, trg_d;
   logic [5:0] irq_q, irq_d;
   logic [4:0] pg_ddr;

   assign bus_mode = (mode_q != PPFS_MODE_7);
   assign pg_ddr = {cs0_dir_q, pg_ddr_low};

   always_comb
   begin
      // port defaults, overridden in the bus modes and by the clock pin and timer outputs in any mode
      pe_out_d = pe_dr;
      pe_oe_d = pe_ddr;
      pf_out_d = pf_dr;
      pf_oe_d = pf_ddr;
      pg_out_d = pg_dr;
      pg_oe_d = pg_ddr;
      p1_out_d = p1_dr;
      p1_oe_d = p1_ddr;
      // low data byte carries the bus only with a 16-bit bus
      if (bus_mode && !bus_width_8)
      begin
         pe_out_d = data_lo_out;
         pe_oe_d = {8{data_lo_drive}};
      end
      // clock pin follows its direction bit in every mode
      pf_out_d[PPFS_PF_CLK] = pf_ddr[PPFS_PF_CLK] ? clk_out_level : pf_dr[PPFS_PF_CLK];
      if (bus_mode)
      begin
         // address strobe, read and high write strobes
         if (!addr_strobe_disable)
         begin
            pf_out_d[PPFS_PF_AS] = address_strobe_n;
            pf_oe_d[PPFS_PF_AS] = 1'b1;
         end
         pf_out_d[PPFS_PF_RD] = read_strobe_n;
         pf_oe_d[PPFS_PF_RD] = 1'b1;
         pf_out_d[PPFS_PF_HWR] = high_write_strobe_n;
         pf_oe_d[PPFS_PF_HWR] = 1'b1;
         // low write strobe released only in 8-bit bus mode
         if (!(bus_width_8 && low_write_strobe_disable))
         begin
            pf_out_d[PPFS_PF_LWR] = low_write_strobe_n;
            pf_oe_d[PPFS_PF_LWR] = 1'b1;
         end
         // wait input turns the pin around
         if (wait_input_enable)
         begin
            pf_oe_d[PPFS_PF_WAIT] = 1'b0;
         end
         // bus release owns both pins over the chip selects
         if (bus_release_enable)
         begin
            pf_out_d[PPFS_PF_BACK] = bus_ack_n;
            pf_oe_d[PPFS_PF_BACK] = 1'b1;
            pf_oe_d[PPFS_PF_BUS_REQUEST_IN] = 1'b0;
         end
         else
         begin
            if (chip_sel_2_to_5_enable && chip_sel_5_pin_select && pf_ddr[PPFS_PF_BACK])
            begin
               pf_out_d[PPFS_PF_BACK] = chip_sel_n[5];
            end
            // all three bits needed before chip select 4 drives
            if (chip_sel_2_to_5_enable && chip_sel_4_pin_select && pf_ddr[PPFS_PF_BUS_REQUEST_IN])
            begin
               pf_out_d[PPFS_PF_BUS_REQUEST_IN] = chip_sel_n[4];
            end
         end
         // chip select 0 driven while its direction is output
         if (pg_ddr[PPFS_PG_CS0])
         begin
            pg_out_d[PPFS_PG_CS0] = chip_sel_n[0];
         end
         if (pg_ddr[PPFS_PG_CS1] && chip_sel_1_6_7_enable)
         begin
            pg_out_d[PPFS_PG_CS1] = chip_sel_1_or_7_choice ? chip_sel_n[7] : chip_sel_n[1];
         end
         if (pg_ddr[PPFS_PG_CS2] && chip_sel_2_to_5_enable)
         begin
            pg_out_d[PPFS_PG_CS2] = chip_sel_n[2];
         end
         // the choice bit picks chip select 3 or 6
         if (pg_ddr[PPFS_PG_CS3] && !chip_sel_3_or_6_choice && chip_sel_2_to_5_enable)
         begin
            pg_out_d[PPFS_PG_CS3] = chip_sel_n[3];
         end
         else if (pg_ddr[PPFS_PG_CS3] && chip_sel_3_or_6_choice && chip_sel_1_6_7_enable)
         begin
            pg_out_d[PPFS_PG_CS3] = chip_sel_n[6];
         end
         // per-pin address or port data choice
         for (int i = 0; i < PPFS_TOP_ADDR_W; i++)
         begin
            // address enable at 1 routes the address line
            if (top_addr_enable[i] && p1_ddr[i])
            begin
               p1_out_d[i] = addr_top[i];
            end
         end
      end
      // an active timer output takes the shared pin in any mode
      for (int i = 0; i < PPFS_TOP_ADDR_W; i++)
      begin
         if (timer_oe[i])
         begin
            p1_out_d[i] = timer_out[i];
            p1_oe_d[i] = 1'b1;
         end
      end
      // bus request only reaches the bus side while enabled
      bus_request_in_d = bus_mode && bus_release_enable && pin_sync[PPFS_PF_BUS_REQUEST_IN];
      // wait seen by the bus only while enabled
      wait_d = bus_mode && wait_input_enable && pin_sync[PPFS_PF_WAIT];
      // irq and trigger inputs stay live whatever the pin drives
      irq_d = pin_sync;
      trg_d = pin_sync[4];
      if (!clk_en)
      begin
         pe_out_d = pe_out_q;
         pe_oe_d = pe_oe_q;
         pf_out_d = pf_out_q;
         pf_oe_d = pf_oe_q;
         pg_out_d = pg_out_q;
         pg_oe_d = pg_oe_q;
         p1_out_d = p1_out_q;
         p1_oe_d = p1_oe_q;
         bus_request_in_d = bus_request_in_q;
         wait_d = wait_q;
         irq_d = irq_q;
         trg_d = trg_q;
      end
   end

   // registered pins cost a cycle of latency but keep pads glitch free
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         pe_out_q <= PPFS_BYTE_RST;
         pe_oe_q <= PPFS_BYTE_RST;
         pf_out_q <= PPFS_BYTE_RST;
         pf_oe_q <= PPFS_BYTE_RST;
         pg_out_q <= PPFS_PG_RST;
         pg_oe_q <= PPFS_PG_RST;
         p1_out_q <= PPFS_NIB_RST;
         p1_oe_q <= PPFS_NIB_RST;
         bus_request_in_q <= 1'b0;
         wait_q <= 1'b0;
         irq_q <= PPFS_IRQ_RST;
         trg_q <= 1'b0;
      end
      else
      begin
         pe_out_q <= pe_out_d;
         pe_oe_q <= pe_oe_d;
         pf_out_q <= pf_out_d;
         pf_oe_q <= pf_oe_d;
         pg_out_q <= pg_out_d;
         pg_oe_q <= pg_oe_d;
         p1_out_q <= p1_out_d;
         p1_oe_q <= p1_oe_d;
         bus_request_in_q <= bus_request_in_d;
         wait_q <= wait_d;
         irq_q <= irq_d;
         trg_q <= trg_d;
      end
   end

   assign op_mode = mode_q;
   assign cs0_dir = cs0_dir_q;
   assign pe_out = pe_out_q;
   assign pe_oe = pe_oe_q;
   assign pf_out = pf_out_q;
   assign pf_oe = pf_oe_q;
   assign pg_out = pg_out_q;
   assign pg_oe = pg_oe_q;
   assign p1_out = p1_out_q;
   assign p1_oe = p1_oe_q;
   assign wait_to_bus = wait_q;
   assign bus_request_in = bus_request_in_q;
   assign converter_trigger_in = trg_q;
   assign irq_level = irq_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   lo_port_io_a: assert property (clk_en && (bus_width_8 || !bus_mode) |=>
      pe_oe == $past(pe_ddr) && pe_out == $past(pe_dr)) else $error("low byte not port");
   clk_pin_a: assert property (clk_en |=> pf_oe[7] == $past(pf_ddr[7]) &&
      (!pf_oe[7] || pf_out[7] == $past(clk_out_level))) else $error("clock pin wrong");
   lwr_release_a: assert property (clk_en && bus_mode && bus_width_8 &&
      low_write_strobe_disable |=> pf_oe[3] == $past(pf_ddr[3])) else $error("lwr pin wrong");
   wait_input_a: assert property (clk_en && bus_mode && wait_input_enable |=>
      !pf_oe[2]) else $error("wait pin driven");
   cs4_gate_a: assert property (clk_en && bus_mode && !bus_release_enable &&
      !(chip_sel_2_to_5_enable && chip_sel_4_pin_select && pf_ddr[0]) |=>
      pf_out[0] == $past(pf_dr[0]))
      else $error("cs4 leaked");
   bus_release_a: assert property (clk_en && bus_mode && bus_release_enable |=>
      !pf_oe[0] && pf_oe[1] && pf_out[1] == $past(bus_ack_n)) else $error("release pins");
   cs0_default_a: assert property (clk_en && lock_q == 2'h1 |=>
      cs0_dir_q == !(HAS_INT_ROM && $past(mode_sync[2]) && $past(mode_sync[1])))
      else $error("cs0 default");
   mode_legal_a: assert property (!HAS_INT_ROM |->
      mode_q == PPFS_MODE_4 || mode_q == PPFS_MODE_5) else $error("mode not offered");
   top_addr_a: assert property (clk_en && bus_mode && timer_oe[0] == 1'b0 && p1_ddr[0] |=>
      p1_out[0] == ($past(top_addr_enable[0]) ? $past(addr_top[0]) : $past(p1_dr[0])))
      else $error("top address pin");
   cs36_pick_a: assert property (clk_en && bus_mode && pg_ddr[1] && chip_sel_3_or_6_choice &&
      chip_sel_1_6_7_enable |=> pg_out[1] == $past(chip_sel_n[6])) else $error("cs6 pick");
   strobes_a: assert property (clk_en && bus_mode |=> pf_oe[5] && pf_oe[4] &&
      pf_oe[6] == (!$past(addr_strobe_disable) || $past(pf_ddr[6]))) else $error("strobes");
   single_chip_a: assert property (clk_en && !bus_mode |=> pf_oe == $past(pf_ddr) &&
      pg_oe == $past(pg_ddr)) else $error("mode 7 pins");

endmodule
`default_nettype wire

/* ppfs_bus_partner.sv */
// far-side bus master and interrupt sources for the pin selector
`timescale 1ns/1ps
`default_nettype none
module ppfs_bus_partner
#(
   parameter logic [31:0] SEED = 32'hCD2720C0
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [3:0] dut_pf_out,
   input wire logic [3:0] dut_pf_oe,
   input wire logic [1:0] dut_pg_out,
   input wire logic [1:0] dut_pg_oe,
   output logic [3:0] pf_pin_in,
   output logic [1:0] pg_pin_in
);
   logic [31:0] seed = SEED;
   logic [31:0] rnd;
   logic req_n = 1'b1;
   logic wait_n = 1'b1;
   logic [3:0] irq_q = 4'hF;
   int hold = 0;
   // --------------------------------
   // wire level: a driving dut wins
   // --------------------------------
   assign pf_pin_in = (dut_pf_oe & dut_pf_out) | (~dut_pf_oe & {irq_q[0], wait_n, irq_q[1], req_n});
   assign pg_pin_in = (dut_pg_oe & dut_pg_out) | (~dut_pg_oe & irq_q[3:2]);
   always @(negedge sys_clk)
   begin
      rnd = $random(seed);
      if (!rst_n)
         req_n <= 1'b1;
      else if (req_n)
         req_n <= (rnd[3:0] != 4'h0);
      else if ((dut_pf_oe[1] && !dut_pf_out[1]) || hold == 24)
         req_n <= 1'b1;
      hold <= req_n ? 0 : hold + 1;
      // stalls vary from none to several cycles
      wait_n <= (rnd[5:4] != 2'h0);
      irq_q <= rnd[11:8];
   end
endmodule
`default_nettype wire

/* ppfs_top_tb_top.sv */
// self-checking bench for the port pin function selector
`timescale 1ns/1ps
`default_nettype none
module ppfs_top_tb_top
   import ppfs_pkg::*;
();
   logic sys_clk = 1'b0;
   logic rst_n, clk_en, bus_width_8, addr_strobe_disable, low_write_strobe_disable;
   logic wait_input_enable, chip_sel_2_to_5_enable, chip_sel_4_pin_select;
   logic chip_sel_5_pin_select, chip_sel_3_or_6_choice, chip_sel_1_or_7_choice;
   logic chip_sel_1_6_7_enable, bus_release_enable, cs0_dir_wr, cs0_dir_wdata;
   logic clk_out_level, address_strobe_n, read_strobe_n, high_write_strobe_n;
   logic low_write_strobe_n, bus_ack_n, data_lo_drive, cs0_dir;
   logic wait_to_bus, bus_request_in, converter_trigger_in;
   logic [2:0] mode_pins;
   logic [3:0] top_addr_enable, addr_top, timer_out, timer_oe, pg_ddr_low, p1_dr, p1_ddr;
   logic [3:0] pf_pin_in, p1_out, p1_oe;
   logic [1:0] pg_pin_in;
   logic [4:0] pg_dr, pg_out, pg_oe;
   logic [5:0] irq_level;
   logic [7:0] chip_sel_n, data_lo_out, pe_dr, pe_ddr, pf_dr, pf_ddr;
   logic [7:0] pe_out, pe_oe, pf_out, pf_oe;
   ppfs_mode_t op_mode, e_mode;
   logic [7:0] e_pe_out, e_pe_oe, e_pf_out, e_pf_oe;
   logic [4:0] e_pg_out, e_pg_oe;
   logic [3:0] e_p1_out, e_p1_oe;
   logic [5:0] e_irq, s1, s2;
   logic e_cs0, e_wait, e_bus_request_in, e_trg, bus;
   logic [31:0] seed = 32'hCD2720C0;
   int n_errors = 0;
   int n_compared = 0;

   always #2.5 sys_clk = ~sys_clk;

   ppfs_top u_dut (.sys_clk, .rst_n, .clk_en, .mode_pins, .bus_width_8, .addr_strobe_disable,
      .low_write_strobe_disable, .wait_input_enable, .chip_sel_2_to_5_enable,
      .chip_sel_4_pin_select, .chip_sel_5_pin_select, .chip_sel_3_or_6_choice,
      .chip_sel_1_or_7_choice, .chip_sel_1_6_7_enable, .bus_release_enable, .top_addr_enable,
      .cs0_dir_wr, .cs0_dir_wdata, .clk_out_level, .addr_top, .address_strobe_n,
      .read_strobe_n, .high_write_strobe_n, .low_write_strobe_n, .bus_ack_n, .chip_sel_n,
      .data_lo_out, .data_lo_drive, .timer_out, .timer_oe, .pe_dr, .pe_ddr, .pf_dr, .pf_ddr,
      .pg_dr, .pg_ddr_low, .p1_dr, .p1_ddr, .pf_pin_in, .pg_pin_in, .op_mode, .cs0_dir,
      .pe_out, .pe_oe, .pf_out, .pf_oe, .pg_out, .pg_oe, .p1_out, .p1_oe, .wait_to_bus,
      .bus_request_in, .converter_trigger_in, .irq_level);

   ppfs_bus_partner u_far (.sys_clk, .rst_n, .dut_pf_out(pf_out[3:0]), .dut_pf_oe(pf_oe[3:0]),
      .dut_pg_out(pg_out[1:0]), .dut_pg_oe(pg_oe[1:0]), .pf_pin_in, .pg_pin_in);

   // --------------------------------
   // reference model, one edge behind
   // --------------------------------
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         {e_pe_out, e_pe_oe, e_pf_out, e_pf_oe, e_pg_out, e_pg_oe, e_p1_out, e_p1_oe} = '0;
         {e_wait, e_bus_request_in, e_trg, e_irq, e_cs0} = '0;
         // synchroniser keeps filling while reset is held
         {s2, s1} = {s1, pg_pin_in, pf_pin_in};
      end
      else if (clk_en)
      begin
         // data byte only on 16-bit bus
         {e_pe_out, e_pe_oe} = (bus && !bus_width_8) ? {data_lo_out, {8{data_lo_drive}}}
            : {pe_dr, pe_ddr};
         {e_pf_out, e_pf_oe} = {pf_dr, pf_ddr};
         e_pf_out[7] = clk_out_level;
         if (bus && !addr_strobe_disable)
            {e_pf_out[6], e_pf_oe[6]} = {address_strobe_n, 1'b1};
         if (bus)
            {e_pf_out[5:4], e_pf_oe[5:4]} = {read_strobe_n, high_write_strobe_n, 2'h3};
         if (bus && !(bus_width_8 && low_write_strobe_disable))
            {e_pf_out[3], e_pf_oe[3]} = {low_write_strobe_n, 1'b1};
         if (bus && wait_input_enable)
            e_pf_oe[2] = 1'b0;
         if (bus && bus_release_enable)
            {e_pf_out[1:0], e_pf_oe[1:0]} = {bus_ack_n, 1'b0, 2'h2};
         else if (bus && chip_sel_2_to_5_enable)
         begin
            if (chip_sel_5_pin_select && pf_ddr[1])
               e_pf_out[1] = chip_sel_n[5];
            if (chip_sel_4_pin_select && pf_ddr[0])
               e_pf_out[0] = chip_sel_n[4];
         end
         {e_pg_out, e_pg_oe} = {pg_dr, e_cs0, pg_ddr_low};
         if (bus && e_cs0)
            e_pg_out[4] = chip_sel_n[0];
         if (bus && pg_ddr_low[3] && chip_sel_1_6_7_enable)
            e_pg_out[3] = chip_sel_1_or_7_choice ? chip_sel_n[7] : chip_sel_n[1];
         if (bus && pg_ddr_low[2] && chip_sel_2_to_5_enable)
            e_pg_out[2] = chip_sel_n[2];
         if (bus && pg_ddr_low[1] && chip_sel_2_to_5_enable && !chip_sel_3_or_6_choice)
            e_pg_out[1] = chip_sel_n[3];
         else if (bus && pg_ddr_low[1] && chip_sel_3_or_6_choice && chip_sel_1_6_7_enable)
            e_pg_out[1] = chip_sel_n[6];
         {e_p1_out, e_p1_oe} = {p1_dr, p1_ddr};
         for (int i = 0; i < 4; i++)
            if (timer_oe[i])
               {e_p1_out[i], e_p1_oe[i]} = {timer_out[i], 1'b1};
            else if (bus && top_addr_enable[i] && p1_ddr[i])
               e_p1_out[i] = addr_top[i];
         // two sync stages then the output flop
         {e_wait, e_bus_request_in, e_irq, e_trg} = {bus & wait_input_enable & s2[2],
            bus & bus_release_enable & s2[0], s2, s2[4]};
         s2 = s1;
         s1 = {pg_pin_in, pf_pin_in};
         if (cs0_dir_wr)
            e_cs0 = cs0_dir_wdata;
      end
   end

   // --------------------------------
   // compare and report
   // --------------------------------
   task cmp_pin(input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
   begin
      n_compared++;
      if ((g & m) !== (e & m))
      begin
         n_errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, e & m, g & m);
      end
   end
   endtask

   task cmp_stat(input logic [7:0] e, input logic [7:0] g);
   begin
      cmp_pin(e, g, 8'hFF);
   end
   endtask

   task compare_all;
   begin
      cmp_stat({4'h0, e_mode}, {4'h0, op_mode});
      cmp_stat({7'h0, e_cs0}, {7'h0, cs0_dir});
      cmp_pin(e_pe_oe, pe_oe, 8'hFF);
      cmp_pin(e_pe_out, pe_out, e_pe_oe);
      cmp_pin(e_pf_oe, pf_oe, 8'hFF);
      cmp_pin(e_pf_out, pf_out, e_pf_oe);
      cmp_pin({3'h0, e_pg_oe}, {3'h0, pg_oe}, 8'hFF);
      cmp_pin({3'h0, e_pg_out}, {3'h0, pg_out}, {3'h0, e_pg_oe});
      cmp_pin({4'h0, e_p1_oe}, {4'h0, p1_oe}, 8'hFF);
      cmp_pin({4'h0, e_p1_out}, {4'h0, p1_out}, {4'h0, e_p1_oe});
      cmp_stat({e_wait, e_bus_request_in, e_irq}, {wait_to_bus, bus_request_in, irq_level});
      cmp_stat({7'h0, e_trg}, {7'h0, converter_trigger_in});
   end
   endtask

   task drive_rand;
   begin
      {bus_width_8, addr_strobe_disable, low_write_strobe_disable, wait_input_enable,
         chip_sel_2_to_5_enable, chip_sel_4_pin_select, chip_sel_5_pin_select,
         chip_sel_3_or_6_choice, chip_sel_1_or_7_choice, chip_sel_1_6_7_enable,
         bus_release_enable, top_addr_enable} = 15'($random(seed));
      {pe_dr, pe_ddr, pf_dr, pf_ddr} = $random(seed);
      {pg_dr, pg_ddr_low, p1_dr, p1_ddr, addr_top, timer_out, timer_oe} = 29'($random(seed));
      {chip_sel_n, data_lo_out, data_lo_drive, address_strobe_n, read_strobe_n,
         high_write_strobe_n, low_write_strobe_n, bus_ack_n, clk_out_level} = 23'($random(seed));
      // sparse timer drive so address paths get exercised
      timer_oe = timer_oe & 4'($random(seed));
      clk_en = (($random(seed) & 7) != 0);
      cs0_dir_wr = (($random(seed) & 7) == 0);
      cs0_dir_wdata = 1'($random(seed));
   end
   endtask

   task summarize;
   begin
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask

   task run_mode(input int code);
   begin
      @(negedge sys_clk);
      {rst_n, clk_en, cs0_dir_wr, mode_pins, bus} = {3'b010, 3'(code), code != 7};
      e_mode = code == 5 ? PPFS_MODE_5 : code == 6 ? PPFS_MODE_6
         : code == 7 ? PPFS_MODE_7 : PPFS_MODE_4;
      repeat (6) @(negedge sys_clk);
      cmp_pin(8'h00, pf_oe, 8'hFF);
      cmp_stat({4'h0, PPFS_MODE_4}, {4'h0, op_mode});
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      e_cs0 = (e_mode == PPFS_MODE_4 || e_mode == PPFS_MODE_5);
      @(negedge sys_clk);
      compare_all();
      repeat (400)
      begin
         drive_rand();
         @(negedge sys_clk);
         compare_all();
      end
      $display("mode code %0d finished", code);
   end
   endtask

   initial
   begin
      drive_rand();
      {rst_n, clk_en, cs0_dir_wr, mode_pins} = 6'b010100;
      run_mode(4);
      run_mode(5);
      run_mode(6);
      run_mode(7);
      // an unknown strap code falls back to mode 4
      run_mode(2);
      summarize();
   end

   initial
   begin
      #100000;
      n_errors++;
      summarize();
   end
endmodule
`default_nettype wire
